// ===== src/i2c_slave_pkg.sv
package i2c_slave_pkg;

  // register indices on the plain register port
  localparam logic [2:0] ADDR_UNIT_CTRL  = 3'h0;
  localparam logic [2:0] ADDR_BUS_STATUS = 3'h1;
  localparam logic [2:0] ADDR_SHIFT_DATA = 3'h2;
  localparam logic [2:0] ADDR_OWN_ADDR   = 3'h3;
  localparam logic [2:0] ADDR_TIMEOUT    = 3'h4;
  localparam logic [2:0] ADDR_IRQ_STATUS = 3'h5;
  localparam logic [2:0] ADDR_IRQ_CLEAR  = 3'h6;
  localparam logic [2:0] ADDR_IRQ_ENABLE = 3'h7;

  // reset values
  localparam logic [7:0] RST_UNIT_CTRL  = 8'hE0;
  localparam logic [7:0] RST_BUS_STATUS = 8'h81;
  localparam logic [7:0] RST_OWN_ADDR   = 8'h00;
  localparam logic [7:0] RST_TIMEOUT    = 8'h00;

  // unit control fields
  localparam int         POS_MODE_LSB   = 5;
  localparam int         POS_ENABLE     = 1;
  localparam logic [2:0] MODE_I2C_SLAVE = 3'h6;
  localparam logic [7:0] UNIT_CTRL_MASK = 8'hEE;

  // bus status fields
  localparam int POS_BYTE_DONE  = 7;
  localparam int POS_ADDR_MATCH = 6;
  localparam int POS_BUSY       = 5;
  localparam int POS_DIRECTION  = 4;
  localparam int POS_ACK_SEND   = 3;
  localparam int POS_MASTER_RD  = 2;
  localparam int POS_WAKE_EN    = 1;
  localparam int POS_ACK_RCVD   = 0;
  localparam logic [7:0] BUS_STATUS_WMASK = 8'h1A;

  // timeout control fields
  localparam int POS_TO_EN   = 7;
  localparam int POS_TO_FLAG = 6;

  // interrupt status bits
  localparam int POS_EV_MATCH   = 0;
  localparam int POS_EV_BYTE    = 1;
  localparam int POS_EV_TIMEOUT = 2;
  localparam int NUM_EVENTS     = 3;

  // byte counter landmarks
  localparam logic [3:0] CNT_LAST_BIT = 4'h7;
  localparam logic [3:0] CNT_ACK      = 4'h8;
  localparam logic [3:0] CNT_DONE     = 4'h9;

  // timing: time-out unit is 32 periods of the sub clock
  localparam int CLK_HZ         = 20_000_000;
  localparam int SUB_CLK_HZ     = 32_768;
  localparam int TO_SUB_DIV     = 32;
  localparam int TO_TICK_CYCLES = CLK_HZ / SUB_CLK_HZ * TO_SUB_DIV;

endpackage : i2c_slave_pkg

// ===== src/i2c_slave_status_control.sv
`timescale 1ns/1ps
//
// Overview of operation
// - enable rising in slave mode resets status flags, keeps direction and ack-to-send bits
// - byte-done low while byte moves, set after each 8 bits; interrupt then on received data or own address, at 9th clock when transmitting
// - address-match flag high on own address, low otherwise
// - busy set on START, cleared on STOP
// - direction bit 1 transmits bytes, 0 receives bytes
// - after eight received bits, drive ack-to-send on SDA at 9th clock
// - eighth bit after START stored as master-read flag when the address matches
// - wake enable set: address match raises wake request
// - after transmitting, sample SDA at 9th clock into ack-received flag
// - transmitter continues on ack, releases SDA on no-ack
// - seven address bits MSB first after START compared to own address
// - on match: interrupt, match flag, drive low acknowledge at 9th bit
// - one interrupt for match, byte done, time-out; flags tell them apart
// - START is SDA falling while SCL high; slave never makes one
// - after match hold SCL low until data write or dummy read
// - active only with mode 110 and enable 1, using programmed address
// - own address is bits 7 to 1 of address register
// - time-out overflow clears time-out enable, sets time-out flag, interrupts
//
module i2c_slave_status_control #(
  parameter int unsigned TO_TICK = i2c_slave_pkg::TO_TICK_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  output logic            irq,
  output logic            wake_req
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BYTE,
    ST_HOLD,
    ST_IGNORE
  } link_state_e;

  typedef struct packed {
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_d;
    logic        sda_s1;
    logic        sda_s2;
    logic        sda_d;
    link_state_e state;
    logic        is_addr;
    logic [3:0]  cnt;
    logic [7:0]  shreg;
    logic [7:0]  unit_ctrl;
    logic [7:0]  bus_status;
    logic [7:0]  shift_data;
    logic [7:0]  own_addr;
    logic [7:0]  timeout_ctrl;
    logic [2:0]  irq_status;
    logic [2:0]  irq_enable;
    logic        active_d;
    logic [31:0] tick_cnt;
    logic [5:0]  to_cnt;
    logic [7:0]  rdata;
    logic        scl_oe;
    logic        sda_oe;
    logic        irq;
    logic        wake;
  } state_s;

  state_s q;
  state_s n;

  function automatic logic hit(input logic [2:0] addr, input logic [2:0] idx);
    hit = (addr == idx);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  logic       active;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       tx_mode;
  logic [2:0] events;
  logic       to_run;
  logic       to_over;

  always_comb begin
    active    = (q.unit_ctrl[7:5] == i2c_slave_pkg::MODE_I2C_SLAVE) &&
                q.unit_ctrl[i2c_slave_pkg::POS_ENABLE];
    scl_rise  = q.scl_s2 && !q.scl_d;
    scl_fall  = !q.scl_s2 && q.scl_d;
    start_det = q.scl_s2 && q.scl_d && q.sda_d && !q.sda_s2;
    stop_det  = q.scl_s2 && q.scl_d && !q.sda_d && q.sda_s2;
    tx_mode   = q.bus_status[i2c_slave_pkg::POS_DIRECTION];
    to_run    = active && q.timeout_ctrl[i2c_slave_pkg::POS_TO_EN] &&
                q.bus_status[i2c_slave_pkg::POS_BUSY] &&
                q.bus_status[i2c_slave_pkg::POS_ADDR_MATCH] && !scl_fall;
    to_over   = to_run && (q.tick_cnt == 32'(TO_TICK - 1)) &&
                (q.to_cnt == q.timeout_ctrl[5:0]);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n        = q;
    events   = 3'h0;
    n.scl_s1 = scl_i;
    n.scl_s2 = q.scl_s1;
    n.scl_d  = q.scl_s2;
    n.sda_s1 = sda_i;
    n.sda_s2 = q.sda_s1;
    n.sda_d  = q.sda_s2;
    n.active_d = active;
    n.rdata  = 8'h00;
    n.wake   = 1'b0;

    // register writes
    if (reg_wr) begin
      if (hit(reg_addr, i2c_slave_pkg::ADDR_UNIT_CTRL)) begin
        n.unit_ctrl = reg_wdata & i2c_slave_pkg::UNIT_CTRL_MASK;
      end
      if (hit(reg_addr, i2c_slave_pkg::ADDR_BUS_STATUS)) begin
        n.bus_status = (q.bus_status & ~i2c_slave_pkg::BUS_STATUS_WMASK) |
                       (reg_wdata & i2c_slave_pkg::BUS_STATUS_WMASK);
      end
      if (hit(reg_addr, i2c_slave_pkg::ADDR_SHIFT_DATA)) begin
        n.shift_data = reg_wdata;
      end
      if (hit(reg_addr, i2c_slave_pkg::ADDR_OWN_ADDR)) begin
        n.own_addr = reg_wdata;
      end
      if (hit(reg_addr, i2c_slave_pkg::ADDR_TIMEOUT)) begin
        n.timeout_ctrl = reg_wdata;
      end
      if (hit(reg_addr, i2c_slave_pkg::ADDR_IRQ_ENABLE)) begin
        n.irq_enable = reg_wdata[2:0];
      end
    end

    // register reads, data one cycle later
    if (reg_rd) begin
      case (reg_addr)
        i2c_slave_pkg::ADDR_UNIT_CTRL:  n.rdata = q.unit_ctrl;
        i2c_slave_pkg::ADDR_BUS_STATUS: n.rdata = q.bus_status;
        i2c_slave_pkg::ADDR_SHIFT_DATA: n.rdata = q.shift_data;
        i2c_slave_pkg::ADDR_OWN_ADDR:   n.rdata = q.own_addr;
        i2c_slave_pkg::ADDR_TIMEOUT:    n.rdata = q.timeout_ctrl;
        i2c_slave_pkg::ADDR_IRQ_STATUS: n.rdata = {5'h00, q.irq_status};
        i2c_slave_pkg::ADDR_IRQ_ENABLE: n.rdata = {5'h00, q.irq_enable};
        default:                        n.rdata = 8'h00;
      endcase
    end

    // enable rising: flags back to defaults
    if (active && !q.active_d) begin
      n.bus_status[i2c_slave_pkg::POS_BYTE_DONE]  = 1'b1;
      n.bus_status[i2c_slave_pkg::POS_ADDR_MATCH] = 1'b0;
      n.bus_status[i2c_slave_pkg::POS_BUSY]       = 1'b0;
      n.bus_status[i2c_slave_pkg::POS_MASTER_RD]  = 1'b0;
      n.bus_status[i2c_slave_pkg::POS_ACK_RCVD]   = 1'b1;
    end

    // link engine
    if (!active) begin
      n.state  = ST_IDLE;
      n.scl_oe = 1'b0;
      n.sda_oe = 1'b0;
    end else if (stop_det) begin
      n.state  = ST_IDLE;
      n.scl_oe = 1'b0;
      n.sda_oe = 1'b0;
      n.bus_status[i2c_slave_pkg::POS_BUSY] = 1'b0;
    end else if (start_det) begin
      n.state   = ST_BYTE;
      n.is_addr = 1'b1;
      n.cnt     = 4'h0;
      n.scl_oe  = 1'b0;
      n.sda_oe  = 1'b0;
      n.bus_status[i2c_slave_pkg::POS_BUSY]       = 1'b1;
      n.bus_status[i2c_slave_pkg::POS_ADDR_MATCH] = 1'b0;
      n.bus_status[i2c_slave_pkg::POS_BYTE_DONE]  = 1'b0;
    end else begin
      case (q.state)
        ST_BYTE: begin
          if (scl_rise) begin
            if (q.cnt < i2c_slave_pkg::CNT_ACK) begin
              n.cnt = q.cnt + 4'h1;
              if (q.is_addr || !tx_mode) begin
                n.shreg = {q.shreg[6:0], q.sda_s2};
              end
              if (q.cnt == i2c_slave_pkg::CNT_LAST_BIT) begin
                n.bus_status[i2c_slave_pkg::POS_BYTE_DONE] = 1'b1;
                if (q.is_addr) begin
                  if (q.shreg[6:0] == q.own_addr[7:1]) begin
                    n.bus_status[i2c_slave_pkg::POS_ADDR_MATCH] = 1'b1;
                    n.bus_status[i2c_slave_pkg::POS_MASTER_RD]  = q.sda_s2;
                    events[i2c_slave_pkg::POS_EV_MATCH] = 1'b1;
                    n.wake = q.bus_status[i2c_slave_pkg::POS_WAKE_EN];
                  end else begin
                    n.state = ST_IGNORE;
                  end
                end else if (!tx_mode) begin
                  n.shift_data = {q.shreg[6:0], q.sda_s2};
                  events[i2c_slave_pkg::POS_EV_BYTE] = 1'b1;
                end
              end
            end else if (q.cnt == i2c_slave_pkg::CNT_ACK) begin
              n.cnt = i2c_slave_pkg::CNT_DONE;
              if (!q.is_addr && tx_mode) begin
                n.bus_status[i2c_slave_pkg::POS_ACK_RCVD] = q.sda_s2;
                events[i2c_slave_pkg::POS_EV_BYTE] = 1'b1;
              end
            end
          end else if (scl_fall) begin
            if (q.cnt == i2c_slave_pkg::CNT_ACK) begin
              if (q.is_addr) begin
                n.sda_oe = 1'b1;
              end else if (tx_mode) begin
                n.sda_oe = 1'b0;
              end else begin
                n.sda_oe = !q.bus_status[i2c_slave_pkg::POS_ACK_SEND];
              end
            end else if (q.cnt == i2c_slave_pkg::CNT_DONE) begin
              n.sda_oe = 1'b0;
              if (!q.is_addr && tx_mode && q.bus_status[i2c_slave_pkg::POS_ACK_RCVD]) begin
                n.state = ST_IGNORE;
              end else begin
                n.state  = ST_HOLD;
                n.scl_oe = 1'b1;
              end
            end else if (!q.is_addr && tx_mode && q.cnt != 4'h0) begin
              n.shreg  = {q.shreg[6:0], 1'b0};
              n.sda_oe = !q.shreg[6];
            end
          end
        end
        ST_HOLD: begin
          if (reg_wr && hit(reg_addr, i2c_slave_pkg::ADDR_SHIFT_DATA) && tx_mode) begin
            n.state   = ST_BYTE;
            n.is_addr = 1'b0;
            n.cnt     = 4'h0;
            n.shreg   = reg_wdata;
            n.sda_oe  = !reg_wdata[7];
            n.scl_oe  = 1'b0;
            n.bus_status[i2c_slave_pkg::POS_BYTE_DONE] = 1'b0;
          end else if (reg_rd && hit(reg_addr, i2c_slave_pkg::ADDR_SHIFT_DATA) && !tx_mode) begin
            n.state   = ST_BYTE;
            n.is_addr = 1'b0;
            n.cnt     = 4'h0;
            n.scl_oe  = 1'b0;
            n.bus_status[i2c_slave_pkg::POS_BYTE_DONE] = 1'b0;
          end
        end
        ST_IGNORE: begin
          n.sda_oe = 1'b0;
          n.scl_oe = 1'b0;
        end
        default: begin
          n.state  = ST_IDLE;
          n.sda_oe = 1'b0;
          n.scl_oe = 1'b0;
        end
      endcase
    end

    // bus time-out
    if (!to_run) begin
      n.tick_cnt = 32'h0;
      n.to_cnt   = 6'h0;
    end else if (q.tick_cnt == 32'(TO_TICK - 1)) begin
      n.tick_cnt = 32'h0;
      n.to_cnt   = q.to_cnt + 6'h1;
    end else begin
      n.tick_cnt = q.tick_cnt + 32'h1;
    end
    if (to_over) begin
      n.timeout_ctrl[i2c_slave_pkg::POS_TO_EN]   = 1'b0;
      n.timeout_ctrl[i2c_slave_pkg::POS_TO_FLAG] = 1'b1;
      n.bus_status = i2c_slave_pkg::RST_BUS_STATUS;
      n.state      = ST_IDLE;
      n.scl_oe     = 1'b0;
      n.sda_oe     = 1'b0;
      events[i2c_slave_pkg::POS_EV_TIMEOUT] = 1'b1;
    end

    // sticky interrupt causes, set wins over clear
    n.irq_status = q.irq_status;
    if (reg_wr && hit(reg_addr, i2c_slave_pkg::ADDR_IRQ_CLEAR)) begin
      n.irq_status = q.irq_status & ~reg_wdata[2:0];
    end
    n.irq_status = n.irq_status | events;
    n.irq        = |(n.irq_status & n.irq_enable);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (reset) begin
      q              <= '0;
      q.scl_s1       <= 1'b1;
      q.scl_s2       <= 1'b1;
      q.scl_d        <= 1'b1;
      q.sda_s1       <= 1'b1;
      q.sda_s2       <= 1'b1;
      q.sda_d        <= 1'b1;
      q.state        <= ST_IDLE;
      q.unit_ctrl    <= i2c_slave_pkg::RST_UNIT_CTRL;
      q.bus_status   <= i2c_slave_pkg::RST_BUS_STATUS;
      q.own_addr     <= i2c_slave_pkg::RST_OWN_ADDR;
      q.timeout_ctrl <= i2c_slave_pkg::RST_TIMEOUT;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata = q.rdata;
  assign scl_o     = 1'b0;
  assign sda_o     = 1'b0;
  assign scl_oe    = q.scl_oe;
  assign sda_oe    = q.sda_oe;
  assign irq       = q.irq;
  assign wake_req  = q.wake;

endmodule : i2c_slave_status_control

// ===== dv/i2c_slave_sva.sv
`timescale 1ns/1ps
module i2c_slave_sva #(
  parameter int unsigned TO_TICK = 4
) (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       scl_i,
  input wire logic       scl_o,
  input wire logic       scl_oe,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       irq,
  input wire logic       wake_req
);
  logic [7:0] ctrl_ff;
  logic       off;

  // shadow of the unit control register
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_ff <= i2c_slave_pkg::RST_UNIT_CTRL;
    end else if (reg_wr && reg_addr == i2c_slave_pkg::ADDR_UNIT_CTRL) begin
      ctrl_ff <= reg_wdata;
    end
  end
  assign off = ctrl_ff[7:5] != i2c_slave_pkg::MODE_I2C_SLAVE || !ctrl_ff[i2c_slave_pkg::POS_ENABLE];

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence data_access;
    (reg_rd || reg_wr) && reg_addr == i2c_slave_pkg::ADDR_SHIFT_DATA;
  endsequence
  sequence irq_off_write;
    reg_wr && ((reg_addr == i2c_slave_pkg::ADDR_IRQ_CLEAR && reg_wdata == 8'h07) ||
               (reg_addr == i2c_slave_pkg::ADDR_IRQ_ENABLE && reg_wdata == 8'h00));
  endsequence

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  a_pins_open_drain: assert property (sda_o == 1'b0 && scl_o == 1'b0)
    else $error("pin driven high");
  a_no_start_made: assert property ($rose(sda_oe) |-> !scl_i)
    else $error("sda pulled while scl high");
  a_wake_single: assert property (wake_req |=> !wake_req)
    else $error("wake pulse too long");
  a_wake_then_ack: assert property (wake_req |-> ##[1:20] sda_oe)
    else $error("no acknowledge after match");
  a_stretch_start: assert property ($rose(scl_oe) |-> !scl_i && !sda_oe)
    else $error("stretch begun at wrong time");
  a_stretch_release: assert property (scl_oe ##0 data_access |-> ##[1:2] !scl_oe)
    else $error("scl not released");
  a_irq_off: assert property (irq_off_write |-> ##[1:2] !irq)
    else $error("interrupt stays high");
  a_quiet_off: assert property (off && $past(off) |-> !sda_oe && !scl_oe)
    else $error("pins driven while inactive");
endmodule : i2c_slave_sva

bind i2c_slave_status_control i2c_slave_sva #(.TO_TICK(TO_TICK)) sva_i (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq), .wake_req(wake_req));

// ===== dv/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_m,
  output logic      sda_m
);
  int stalls;

  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
    stalls = 0;
  end

  // release scl, bounded wait while the slave stretches
  task automatic rise();
    scl_m = 1'b1;
    for (int i = 0; i < 2000 && scl !== 1'b1; i++) #50;
    if (scl !== 1'b1) stalls++;
  endtask : rise

  task automatic start();
    sda_m = 1'b1;
    rise();
    #150 sda_m = 1'b0;
    #150 scl_m = 1'b0;
  endtask : start

  task automatic stop();
    #100 sda_m = 1'b0;
    #150 rise();
    #150 sda_m = 1'b1;
    #200;
  endtask : stop

  // nine clocks, msb first; sda changes only while scl low
  task automatic xfer(input logic [8:0] o, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      #100 sda_m = o[i];
      #150 rise();
      #150 r[i] = sda;
      scl_m = 1'b0;
    end
  endtask : xfer
endmodule : i2c_master_model

// ===== dv/i2c_slave_status_control_bench.sv
`timescale 1ns/1ps
module i2c_slave_status_control_bench;
  logic       clk, reset, reg_wr, reg_rd, scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe;
  logic       irq, wake_req, scl_m, sda_m;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [8:0] r;
  int         err_count, checked;
  int         wakes = 0;

  // open-drain wires with pull-ups
  assign scl_i = scl_m & (scl_oe ? scl_o : 1'b1);
  assign sda_i = sda_m & (sda_oe ? sda_o : 1'b1);

  i2c_slave_status_control #(.TO_TICK(4)) uut (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq), .wake_req(wake_req));
  i2c_master_model m (.scl(scl_i), .sda(sda_i), .scl_m(scl_m), .sda_m(sda_m));

  always @(posedge clk) if (wake_req === 1'b1) wakes <= wakes + 1;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic chkr(input logic [2:0] a, input logic [7:0] msk, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v & msk, exp);
  endtask : chkr

  task automatic end_sim();
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    end_sim();
  end

  initial begin
    {reset, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 13'h0000};
    {err_count, checked} = '0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    chkr(3'h1, 8'hFF, 8'h81);
    chkr(3'h0, 8'hFF, 8'hE0);
    chkr(3'h6, 8'hFF, 8'h00);
    // inactive unit stays silent
    m.start();
    m.xfer({8'hA4, 1'b1}, r);
    chk({7'h00, r[0]}, 8'h01);
    m.stop();
    chkr(3'h1, 8'hFF, 8'h81);
    wr(3'h3, 8'hA5);
    wr(3'h0, 8'hC2);
    wr(3'h7, 8'h07);
    wr(3'h1, 8'h02);
    // master writes two bytes
    m.start();
    chkr(3'h1, 8'h20, 8'h20);
    m.xfer({8'hA4, 1'b1}, r);
    chk({7'h00, r[0]}, 8'h00);
    // let the stretch start after the 9th falling edge
    repeat (8) @(posedge clk);
    chkr(3'h1, 8'hFE, 8'hE2);
    chk(wakes[7:0], 8'h01);
    chk({7'h00, scl_oe}, 8'h01);
    chk({7'h00, irq}, 8'h01);
    wr(3'h7, 8'h00);
    chkr(3'h5, 8'hFF, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr(3'h7, 8'h07);
    wr(3'h6, 8'h07);
    rd(3'h2, d);
    chkr(3'h1, 8'h80, 8'h00);
    chk({7'h00, scl_oe}, 8'h00);
    m.xfer({8'h3C, 1'b1}, r);
    chk({7'h00, r[0]}, 8'h00);
    repeat (8) @(posedge clk);
    chkr(3'h5, 8'h02, 8'h02);
    chkr(3'h1, 8'h80, 8'h80);
    chkr(3'h2, 8'hFF, 8'h3C);
    wr(3'h1, 8'h0A);
    m.xfer({8'hC3, 1'b1}, r);
    chk({7'h00, r[0]}, 8'h01);
    repeat (8) @(posedge clk);
    chkr(3'h2, 8'hFF, 8'hC3);
    m.stop();
    chkr(3'h1, 8'h20, 8'h00);
    // address of another slave
    m.start();
    m.xfer({8'h40, 1'b1}, r);
    chk({7'h00, r[0]}, 8'h01);
    chkr(3'h1, 8'h40, 8'h00);
    chk({7'h00, scl_oe}, 8'h00);
    m.stop();
    // master reads, ack then no-ack
    m.start();
    m.xfer({8'hA5, 1'b1}, r);
    chkr(3'h1, 8'h44, 8'h44);
    wr(3'h1, 8'h12);
    wr(3'h2, 8'h9A);
    m.xfer({8'hFF, 1'b0}, r);
    chk(r[8:1], 8'h9A);
    repeat (8) @(posedge clk);
    chkr(3'h1, 8'h01, 8'h00);
    wr(3'h2, 8'h5B);
    m.xfer({8'hFF, 1'b1}, r);
    chk(r[8:1], 8'h5B);
    chkr(3'h1, 8'h01, 8'h01);
    chk({7'h00, sda_oe}, 8'h00);
    m.stop();
    // enable rising keeps direction and ack-to-send bits
    wr(3'h1, 8'h18);
    wr(3'h0, 8'hC0);
    wr(3'h0, 8'hC2);
    chkr(3'h1, 8'hFD, 8'h99);
    wr(3'h1, 8'h00);
    // held clock runs into the time-out
    wr(3'h6, 8'h07);
    wr(3'h4, 8'h83);
    m.start();
    m.xfer({8'hA4, 1'b1}, r);
    repeat (40) @(posedge clk);
    chkr(3'h4, 8'hC0, 8'h40);
    chkr(3'h5, 8'h04, 8'h04);
    chkr(3'h1, 8'hFF, 8'h81);
    m.stop();
    chk(m.stalls[7:0], 8'h00);
    end_sim();
  end
endmodule : i2c_slave_status_control_bench
